/* File: src/speed_fault_config_regs.sv */
// speed profile six and fault configuration register bank
`timescale 1ns/10ps
`include "speed_fault_config_map.svh"
module speed_fault_config_regs #(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output speed_fault_config_pkg::speed_frac_t second_turnoff_speed,
   output speed_fault_config_pkg::speed_frac_t second_clamp_speed,
   output speed_fault_config_pkg::current_code_t torque_loop_current_cap,
   output speed_fault_config_pkg::current_code_t comparator_stall_current,
   output speed_fault_config_pkg::current_code_t adc_stall_current,
   output logic pulse_detect_timeout_enable,
   output logic pulse_detect_rate_enable,
   output logic saturation_flag_enable,
   output logic code_reserved
);
   // a reserved current code is flagged rather than blocked; software may still store it
   function automatic logic is_reserved(input speed_fault_config_pkg::current_code_t c);
      is_reserved = c > `CURRENT_CODE_MAX;
   endfunction

   speed_fault_config_pkg::word_t fault_one_q, fault_two_q, speed_six_q, rdata_q;
   logic code_res_q;
   // one compare shared by every select; a narrower bus truncates the offset on purpose
   function automatic logic hit_offset(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      hit_offset = a == ADDR_W'(off);
   endfunction
   wire sel_one = hit_offset(addr, `FAULT_ONE_OFFSET);
   wire sel_two = hit_offset(addr, `FAULT_TWO_OFFSET);
   wire sel_six = hit_offset(addr, `SPEED_SIX_OFFSET);
   // high when the offset is one of the three registers
   wire any_sel = sel_one | sel_two | sel_six;
   // reserved positions masked on write
   wire speed_fault_config_pkg::word_t one_d = wdata & `FAULT_ONE_WMASK;
   wire speed_fault_config_pkg::word_t two_d = wdata & `FAULT_TWO_WMASK;
   wire speed_fault_config_pkg::word_t six_d = wdata & `SPEED_SIX_WMASK;
   speed_fault_config_pkg::word_t rdata_d;
   // unmapped offsets read zero and ignore writes
   assign rdata_d = !rd ? 32'h0000_0000 :
                    sel_one ? fault_one_q :
                    sel_two ? fault_two_q :
                    sel_six ? speed_six_q : 32'h0000_0000;
   // one detector per current field; all three share the same coding
   localparam int NUM_CAPS = 3;
   speed_fault_config_pkg::current_code_t cap_field [NUM_CAPS];
   logic [NUM_CAPS-1:0] cap_res;
   assign cap_field[0] = fault_one_q[`TORQUE_CAP_MSB:`TORQUE_CAP_LSB];
   assign cap_field[1] = fault_one_q[`CMP_STALL_MSB:`CMP_STALL_LSB];
   assign cap_field[2] = fault_one_q[`ADC_STALL_MSB:`ADC_STALL_LSB];
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CAPS; gi++) begin : g_cap_check
         assign cap_res[gi] = is_reserved(cap_field[gi]);
      end
   endgenerate
   wire code_res_d = |cap_res;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fault_one_q <= `FAULT_ONE_RESET;
         fault_two_q <= `FAULT_TWO_RESET;
         speed_six_q <= `SPEED_SIX_RESET;
         rdata_q <= 32'h0000_0000;
         code_res_q <= 1'b0;
      end else begin
         if (wr && sel_one) fault_one_q <= one_d;
         if (wr && sel_two) fault_two_q <= two_d;
         if (wr && sel_six) speed_six_q <= six_d;
         rdata_q <= rdata_d;
         code_res_q <= code_res_d;
      end
   end

   assign rdata = rdata_q;
   assign second_turnoff_speed = speed_six_q[`TURNOFF_MSB:`TURNOFF_LSB];
   assign second_clamp_speed = speed_six_q[`CLAMP_MSB:`CLAMP_LSB];
   assign torque_loop_current_cap = fault_one_q[`TORQUE_CAP_MSB:`TORQUE_CAP_LSB];
   assign comparator_stall_current = fault_one_q[`CMP_STALL_MSB:`CMP_STALL_LSB];
   assign adc_stall_current = fault_one_q[`ADC_STALL_MSB:`ADC_STALL_LSB];
   assign pulse_detect_timeout_enable = fault_one_q[`TIMEOUT_EN_BIT];
   assign pulse_detect_rate_enable = fault_one_q[`RATE_EN_BIT];
   assign saturation_flag_enable = fault_one_q[`SAT_EN_BIT];
   assign code_reserved = code_res_q;

   // stall fields drive no output port; kept internal, checked on write and readback
   wire [3:0] stall_current_action = fault_one_q[`STALL_MODE_MSB:`STALL_MODE_LSB];
   wire [3:0] stall_current_deglitch = fault_one_q[`STALL_DEG_MSB:`STALL_DEG_LSB];
   wire [3:0] stall_retry_time = fault_one_q[`STALL_RETRY_MSB:`STALL_RETRY_LSB];
   wire [3:0] stall_action = fault_one_q[`STALL_ACT_MSB:`STALL_ACT_LSB];

   // bus phases the checks are built from: a strobe with its decoded offset
   sequence s_wr_one;
      wr && sel_one;
   endsequence
   sequence s_wr_two;
      wr && sel_two;
   endsequence
   sequence s_wr_six;
      wr && sel_six;
   endsequence
   sequence s_rd_one;
      rd && sel_one;
   endsequence
   sequence s_rd_two;
      rd && sel_two;
   endsequence
   sequence s_rd_six;
      rd && sel_six;
   endsequence

   a_turnoff_write: assert property (@(posedge clk) disable iff (!resetn)
      wr && sel_six |=> second_turnoff_speed == $past(wdata[30:23]))
      else $error("turn-off speed not stored");
   a_clamp_write: assert property (@(posedge clk) disable iff (!resetn)
      wr && sel_six |=> second_clamp_speed == $past(wdata[22:15]))
      else $error("clamp speed not stored");
   a_six_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
      rd && sel_six |=> rdata[31] == 1'b0 && rdata[14:0] == 15'h0000)
      else $error("speed six reserved bits nonzero");
   a_fault_one_read: assert property (@(posedge clk) disable iff (!resetn)
      rd && sel_one |=> rdata == $past(fault_one_q))
      else $error("fault one readback wrong");
   a_unmapped_zero: assert property (@(posedge clk) disable iff (!resetn)
      rd && !sel_one && !sel_two && !sel_six |=> rdata == 32'h0000_0000)
      else $error("unmapped read nonzero");
   a_fault_flags: assert property (@(posedge clk) disable iff (!resetn)
      wr && sel_one |=> saturation_flag_enable == $past(wdata[0]) && pulse_detect_timeout_enable == $past(wdata[2]))
      else $error("enable flags not stored");
   a_torque_reserved: assert property (@(posedge clk) disable iff (!resetn)
      torque_loop_current_cap > 4'hd |=> code_reserved)
      else $error("reserved torque code not flagged");
   a_cmp_reserved: assert property (@(posedge clk) disable iff (!resetn)
      comparator_stall_current > 4'hd |=> code_reserved)
      else $error("reserved comparator code not flagged");
   a_adc_reserved: assert property (@(posedge clk) disable iff (!resetn)
      adc_stall_current > 4'hd |=> code_reserved)
      else $error("reserved adc code not flagged");
   a_reserved_dropped: assert property (@(posedge clk) disable iff (!resetn)
      wr && sel_one |=> fault_one_q[31] == 1'b0)
      else $error("fault one bit 31 written");

   // readback, hold, field and reserved-flag checks; readback and field checks use the bus phases above
   a_turnoff_read: assert property (@(posedge clk) disable iff (!resetn)
      s_rd_six |=> rdata[`TURNOFF_MSB:`TURNOFF_LSB] == $past(second_turnoff_speed))
      else $error("turn-off speed readback wrong");
   a_turnoff_hold: assert property (@(posedge clk) disable iff (!resetn)
      !(wr && sel_six) |=> $stable(second_turnoff_speed))
      else $error("turn-off speed changed without a write");
   a_clamp_read: assert property (@(posedge clk) disable iff (!resetn)
      s_rd_six |=> rdata[`CLAMP_MSB:`CLAMP_LSB] == $past(second_clamp_speed))
      else $error("clamp speed readback wrong");
   a_clamp_hold: assert property (@(posedge clk) disable iff (!resetn)
      !(wr && sel_six) |=> $stable(second_clamp_speed))
      else $error("clamp speed changed without a write");
   a_six_read: assert property (@(posedge clk) disable iff (!resetn)
      s_rd_six |=> rdata == $past(speed_six_q))
      else $error("speed six readback wrong");
   a_six_hold: assert property (@(posedge clk) disable iff (!resetn)
      !(wr && sel_six) |=> $stable(speed_six_q))
      else $error("speed six changed without a write");
   a_six_res_store: assert property (@(posedge clk) disable iff (!resetn)
      s_wr_six |=> speed_six_q[31] == 1'b0 && speed_six_q[14:0] == 15'h0000)
      else $error("speed six reserved bits stored");
   a_two_write: assert property (@(posedge clk) disable iff (!resetn)
      s_wr_two |=> fault_two_q == $past(wdata))
      else $error("fault two not stored");
   a_two_read: assert property (@(posedge clk) disable iff (!resetn)
      s_rd_two |=> rdata == $past(fault_two_q))
      else $error("fault two readback wrong");
   a_one_hold: assert property (@(posedge clk) disable iff (!resetn)
      !(wr && sel_one) |=> $stable(fault_one_q))
      else $error("fault one changed without a write");
   a_two_hold: assert property (@(posedge clk) disable iff (!resetn)
      !(wr && sel_two) |=> $stable(fault_two_q))
      else $error("fault two changed without a write");
   a_torque_write: assert property (@(posedge clk) disable iff (!resetn)
      s_wr_one |=> torque_loop_current_cap == $past(wdata[`TORQUE_CAP_MSB:`TORQUE_CAP_LSB]))
      else $error("torque cap not stored as written");
   a_cmp_write: assert property (@(posedge clk) disable iff (!resetn)
      s_wr_one |=> comparator_stall_current == $past(wdata[`CMP_STALL_MSB:`CMP_STALL_LSB]))
      else $error("comparator current not stored as written");
   a_adc_write: assert property (@(posedge clk) disable iff (!resetn)
      s_wr_one |=> adc_stall_current == $past(wdata[`ADC_STALL_MSB:`ADC_STALL_LSB]))
      else $error("adc current not stored as written");
   a_cap_read: assert property (@(posedge clk) disable iff (!resetn)
      s_rd_one |=> rdata[`TORQUE_CAP_MSB:`TORQUE_CAP_LSB] == $past(torque_loop_current_cap))
      else $error("torque cap readback wrong");
   a_cmp_read: assert property (@(posedge clk) disable iff (!resetn)
      s_rd_one |=> rdata[`CMP_STALL_MSB:`CMP_STALL_LSB] == $past(comparator_stall_current))
      else $error("comparator current readback wrong");
   a_adc_read: assert property (@(posedge clk) disable iff (!resetn)
      s_rd_one |=> rdata[`ADC_STALL_MSB:`ADC_STALL_LSB] == $past(adc_stall_current))
      else $error("adc current readback wrong");
   a_rate_flag: assert property (@(posedge clk) disable iff (!resetn)
      s_wr_one |=> pulse_detect_rate_enable == $past(wdata[`RATE_EN_BIT]))
      else $error("rate enable not stored");
   a_flags_read: assert property (@(posedge clk) disable iff (!resetn)
      s_rd_one |=> rdata[`TIMEOUT_EN_BIT] == $past(pulse_detect_timeout_enable)
         && rdata[`RATE_EN_BIT] == $past(pulse_detect_rate_enable)
         && rdata[`SAT_EN_BIT] == $past(saturation_flag_enable))
      else $error("enable flags readback wrong");
   a_stall_write: assert property (@(posedge clk) disable iff (!resetn)
      s_wr_one |=> {stall_current_action, stall_current_deglitch, stall_retry_time, stall_action}
         == $past(wdata[`STALL_MODE_MSB:`STALL_ACT_LSB]))
      else $error("stall fields not stored");
   a_stall_read: assert property (@(posedge clk) disable iff (!resetn)
      s_rd_one |=> rdata[`STALL_MODE_MSB:`STALL_MODE_LSB] == $past(stall_current_action)
         && rdata[`STALL_DEG_MSB:`STALL_DEG_LSB] == $past(stall_current_deglitch)
         && rdata[`STALL_RETRY_MSB:`STALL_RETRY_LSB] == $past(stall_retry_time)
         && rdata[`STALL_ACT_MSB:`STALL_ACT_LSB] == $past(stall_action))
      else $error("stall fields readback wrong");
   a_one_res_read: assert property (@(posedge clk) disable iff (!resetn)
      s_rd_one |=> rdata[31] == 1'b0)
      else $error("fault one reserved bit read nonzero");
   a_legal_no_flag: assert property (@(posedge clk) disable iff (!resetn)
      !(|cap_res) |=> !code_reserved)
      else $error("legal current codes flagged reserved");
   a_unmapped_ignored: assert property (@(posedge clk) disable iff (!resetn)
      wr && !any_sel |=> $stable(fault_one_q) && $stable(fault_two_q)
         && $stable(speed_six_q))
      else $error("unmapped write disturbed a register");
endmodule

/* File: src/speed_fault_config_map.svh */
// register offsets, field positions and reset values for the speed/fault configuration bank
// Contract
// - The second turn-off speed is an 8-bit fraction of maximum speed (value/255*100 %) held in bits 30-23 of speed_profile_six.
// - The second clamp speed is an 8-bit fraction of maximum speed (value/255*100 %) held in bits 22-15 of speed_profile_six.
// - speed_profile_six sits at offset 0x9e, resets to zero, and bit 31 and bits 14-0 read as zero.
// - The fault group is fault_settings_one at 0x90 resetting to zero and fault_settings_two at 0x92.
// - fault_settings_one holds bit 31 reserved, current caps in 30-27, 26-23, 22-19, then the stall fields and three enable flags in bits 2-0.
// - The torque loop current cap uses codes 0x0-0xd for 0.078125 A to 3.75 A, with 0xe and 0xf reserved.
// - The comparator stall current field uses the same current coding with 0xe and 0xf reserved.
// - The adc stall current field uses the same current coding with 0xe and 0xf reserved.
`ifndef SPEED_FAULT_CONFIG_MAP_SVH
`define SPEED_FAULT_CONFIG_MAP_SVH
`define FAULT_ONE_OFFSET 8'h90
`define FAULT_TWO_OFFSET 8'h92
`define SPEED_SIX_OFFSET 8'h9e
`define FAULT_ONE_RESET 32'h0000_0000
`define FAULT_TWO_RESET 32'h0000_0000
`define SPEED_SIX_RESET 32'h0000_0000
`define FAULT_ONE_WMASK 32'h7fff_ffff
`define FAULT_TWO_WMASK 32'hffff_ffff
`define SPEED_SIX_WMASK 32'h7fff_8000
`define TURNOFF_MSB 30
`define TURNOFF_LSB 23
`define CLAMP_MSB 22
`define CLAMP_LSB 15
`define TORQUE_CAP_MSB 30
`define TORQUE_CAP_LSB 27
`define CMP_STALL_MSB 26
`define CMP_STALL_LSB 23
`define ADC_STALL_MSB 22
`define ADC_STALL_LSB 19
`define STALL_MODE_MSB 18
`define STALL_MODE_LSB 15
`define STALL_DEG_MSB 14
`define STALL_DEG_LSB 11
`define STALL_RETRY_MSB 10
`define STALL_RETRY_LSB 7
`define STALL_ACT_MSB 6
`define STALL_ACT_LSB 3
`define TIMEOUT_EN_BIT 2
`define RATE_EN_BIT 1
`define SAT_EN_BIT 0
`define CURRENT_CODE_MAX 4'hd
`endif

/* File: src/speed_fault_config_pkg.sv */
// types for the speed/fault configuration bank
package speed_fault_config_pkg;
   typedef logic [31:0] word_t;
   typedef logic [3:0] current_code_t;
   typedef logic [7:0] speed_frac_t;
endpackage

/* File: verification/speed_fault_config_regs_tb.sv */
// self-checking bench for the speed/fault configuration bank
`timescale 1ns/10ps
module speed_fault_config_regs_tb;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   speed_fault_config_pkg::speed_frac_t turnoff, clamp;
   speed_fault_config_pkg::current_code_t cap, cmp_cur, adc_cur;
   logic te, re, se, cres;
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;
   speed_fault_config_regs u_speed_fault_config_regs (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .second_turnoff_speed(turnoff), .second_clamp_speed(clamp),
      .torque_loop_current_cap(cap), .comparator_stall_current(cmp_cur), .adc_stall_current(adc_cur),
      .pulse_detect_timeout_enable(te), .pulse_detect_rate_enable(re), .saturation_flag_enable(se),
      .code_reserved(cres));
   always #20 clk = ~clk;
   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         num_errors++;
         complete_run();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      // step off the edge so callers see the stored value settled
      #1;
   endtask
   // data stands one cycle only, then must fall back to zero
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a; rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
      @(posedge clk);
      #1 chk(rdata, 32'h0000_0000);
   endtask
   task automatic reset_values();
      rd_reg(8'h9e, 32'h0000_0000);
      rd_reg(8'h90, 32'h0000_0000);
      chk({16'h0000, turnoff, clamp}, 32'h0000_0000);
      chk({16'h0000, cap, cmp_cur, adc_cur, te, re, se, cres}, 32'h0000_0000);
   endtask
   task automatic speed_six();
      wr_reg(8'h9e, 32'haaaa_5555);
      chk({16'h0000, turnoff, clamp}, 32'h0000_5554);
      rd_reg(8'h9e, 32'h2aaa_0000);
      wr_reg(8'h9e, 32'hffff_ffff);
      rd_reg(8'h9e, 32'h7fff_8000);
      chk({16'h0000, turnoff, clamp}, 32'h0000_ffff);
   endtask
   task automatic fault_one();
      wr_reg(8'h90, 32'hffff_ffff);
      rd_reg(8'h90, 32'h7fff_ffff);
      chk({16'h0000, cap, cmp_cur, adc_cur, te, re, se, cres}, 32'h0000_ffff);
      wr_reg(8'h90, 32'h7000_0000);
      rd_reg(8'h90, 32'h7000_0000);
      chk({16'h0000, cap, cmp_cur, adc_cur, te, re, se, cres}, 32'h0000_e001);
      wr_reg(8'h90, 32'h0780_0000);
      rd_reg(8'h90, 32'h0780_0000);
      chk({16'h0000, cap, cmp_cur, adc_cur, te, re, se, cres}, 32'h0000_0f01);
      wr_reg(8'h90, 32'h0070_0000);
      rd_reg(8'h90, 32'h0070_0000);
      chk({16'h0000, cap, cmp_cur, adc_cur, te, re, se, cres}, 32'h0000_00e1);
      wr_reg(8'h90, 32'he838_0005);
      rd_reg(8'h90, 32'h6838_0005);
      chk({16'h0000, cap, cmp_cur, adc_cur, te, re, se, cres}, 32'h0000_d07a);
      wr_reg(8'h92, 32'hffff_ffff);
      rd_reg(8'h92, 32'hffff_ffff);
   endtask
   // reserved fault offset 0x91 is only read; 0x94 and 0x00 are written, then read back as zero
   task automatic unmapped();
      wr_reg(8'h00, 32'hffff_ffff);
      wr_reg(8'h94, 32'h1234_5678);
      rd_reg(8'h91, 32'h0000_0000);
      rd_reg(8'h94, 32'h0000_0000);
      rd_reg(8'h00, 32'h0000_0000);
      rd_reg(8'h90, 32'h6838_0005);
      rd_reg(8'h9e, 32'h7fff_8000);
   endtask
   task automatic complete_run();
      if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      reset_values();
      speed_six();
      fault_one();
      unmapped();
      @(posedge clk);
      resetn <= 1'b0;
      @(posedge clk);
      resetn <= 1'b1;
      reset_values();
      complete_run();
   end
endmodule
